/* File: inc/cbsc_pkg.sv */
// constants and carrier types for the card bridge system control register
package cbsc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] CBSC_SYSCTL_OFF = 8'h80;
  localparam logic [7:0] CBSC_STATUS_OFF = 8'h84;
  localparam logic [25:0] CBSC_RESET_VAL = 26'h0449060;
  // bits that software may write and store
  localparam logic [25:0] CBSC_RW_MASK = 26'h17fc0ff;
  // bit positions of all fields, read-only, write-one-clear and writable
  localparam int CBSC_B_IRQ_FLAG = 25;
  localparam int CBSC_B_IRQ_MODE = 24;
  localparam int CBSC_B_RSVD_ZERO = 23;
  localparam int CBSC_B_SPARE_DRV = 22;
  localparam int CBSC_B_GUARD_OFF = 21;
  localparam int CBSC_B_VID_FLOAT = 20;
  localparam int CBSC_B_DMA_REQ = 19;
  localparam int CBSC_B_CHAN_HI = 18;
  localparam int CBSC_B_CHAN_LO = 16;
  localparam int CBSC_B_BURST_DN = 15;
  localparam int CBSC_B_BURST_UP = 14;
  localparam int CBSC_B_TOUCHED = 13;
  localparam int CBSC_B_RSVD_ONE = 12;
  localparam int CBSC_B_SHIFT = 11;
  localparam int CBSC_B_RISE = 10;
  localparam int CBSC_B_FALL = 9;
  localparam int CBSC_B_PROBE = 8;
  localparam int CBSC_B_AUTO_SW = 7;
  localparam int CBSC_B_IDLE_GATE = 6;
  localparam int CBSC_B_ID_LOCK = 5;
  localparam int CBSC_B_PARITY = 4;
  localparam int CBSC_B_CDMA = 3;
  localparam int CBSC_B_VOLT = 2;
  localparam int CBSC_B_CLK_BLK = 1;
  localparam int CBSC_B_WAKE_MUX = 0;
  localparam logic [2:0] CBSC_CHAN_UNUSED = 3'h4;
  // ==========================================================
  // carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cbsc_bus_req_t;
  typedef struct packed {
    logic shift_busy;
    logic rise_busy;
    logic fall_busy;
    logic probe_busy;
  } cbsc_power_stat_t;
endpackage

/* File: design/cbsc_sysctl.sv */
// card bridge system control register, bits 25 to 0, with its side effects
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// (RL1) mode flag sets on enabled power write, w1c
// (RL2) enabled power write raises management interrupt
// (RL3) bit 23 reads zero, 12 one
// (RL4) spare terminals driven low when set and a cardbus card is inserted
// (RL5) bit 21 clear keeps supply guard on
// (RL6) bit 20 floats four upper addresses
// (RL7) card dma requests pass only when enabled
// (RL8) three-bit dma channel, default four
// (RL9) downstream read burst enable, reset one
// (RL10) upstream read burst enable, reset zero
// (RL11) activity flag sets on access, read clears
// (RL12) bit 11 shows power stream busy
// (RL13) bits 10 and 9 show settle delays
// (RL14) bit 8 shows interrogation in progress
// (RL15) bit 7 gates legacy auto switch
// (RL16) idle clock gate stops state machine clock
// (RL17) bit 5 locks id registers
// (RL18) bit 4 routes parity errors to serr
// (RL19) central dma needs bit 3 and pins
// (RL20) bit 2 picks 3.3 or 5 volts
// (RL21) bit 1 blocks clock stopping
// (RL22) bit 0 selects ring and pme sharing
// (RL23) read-only bits ignore writes
module cbsc_sysctl
  import cbsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic power_write_i,
  input wire logic card_access_i,
  input wire logic cardbus_inserted_i,
  input wire logic card_idle_i,
  input wire logic card_clock_stopped_i,
  input wire logic card_dma_request_i,
  input wire logic central_dma_pins_i,
  input wire logic card_parity_err_i,
  input wire logic clock_stop_req_i,
  input wire logic ring_indicate_out_i,
  input wire logic pme_i,
  input wire logic legacy_mode_i,
  input wire logic auto_switch_req_i,
  input wire cbsc_power_stat_t power_stat_i,
  output logic mgmt_irq_o,
  output logic spare_terminal_drive_o,
  output logic spare_terminal_oe_o,
  output logic supply_guard_on_o,
  output logic video_addr_float_o,
  output logic card_dma_req_o,
  output logic [2:0] card_dma_channel_o,
  output logic read_burst_down_on_o,
  output logic read_burst_up_on_o,
  output logic auto_switch_on_o,
  output logic idle_clock_stop_o,
  output logic id_regs_lock_o,
  output logic serr_o,
  output logic central_dma_on_o,
  output logic legacy_five_volt_o,
  output logic clock_stop_allow_o,
  output logic wake_pin_o
);
  // ==========================================================
  // register state
  logic [25:0] ctrl_reg;
  logic mgmt_irq_flag_reg;
  logic socket_touched_reg;
  logic mgmt_irq_reg;
  logic [31:0] rdata_reg;
  logic wr_hit;
  logic rd_hit;
  logic [25:0] view;

  assign wr_hit = wr_i && (addr_i == CBSC_SYSCTL_OFF);
  assign rd_hit = rd_i && (addr_i == CBSC_SYSCTL_OFF);

  // ==========================================================
  // writable control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CBSC_RESET_VAL & CBSC_RW_MASK; // see (RL8)
    end else if (wr_hit) begin
      ctrl_reg <= wdata_i[25:0] & CBSC_RW_MASK; // see (RL23)
    end
  end

  // ==========================================================
  // sticky status: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_irq_flag_reg <= 1'b0;
    end else if (power_write_i && ctrl_reg[CBSC_B_IRQ_MODE]) begin
      mgmt_irq_flag_reg <= 1'b1; // see (RL1)
    end else if (wr_hit && wdata_i[CBSC_B_IRQ_FLAG]) begin
      mgmt_irq_flag_reg <= 1'b0; // see (RL1)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      socket_touched_reg <= 1'b0;
    end else if (card_access_i) begin
      socket_touched_reg <= 1'b1; // see (RL11)
    end else if (rd_hit) begin
      socket_touched_reg <= 1'b0; // see (RL11)
    end
  end

  // one-cycle management interrupt pulse per enabled power write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_irq_reg <= 1'b0;
    end else begin
      mgmt_irq_reg <= power_write_i && ctrl_reg[CBSC_B_IRQ_MODE]; // see (RL2)
    end
  end

  // ==========================================================
  // read view
  always_comb begin
    view = ctrl_reg;
    view[CBSC_B_IRQ_FLAG] = mgmt_irq_flag_reg;
    view[CBSC_B_RSVD_ZERO] = 1'b0; // see (RL3)
    view[CBSC_B_TOUCHED] = socket_touched_reg;
    view[CBSC_B_RSVD_ONE] = 1'b1; // see (RL3)
    view[CBSC_B_SHIFT] = power_stat_i.shift_busy; // see (RL12)
    view[CBSC_B_RISE] = power_stat_i.rise_busy; // see (RL13)
    view[CBSC_B_FALL] = power_stat_i.fall_busy; // see (RL13)
    view[CBSC_B_PROBE] = power_stat_i.probe_busy; // see (RL14)
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (rd_hit) begin
      rdata_reg <= {6'h0, view};
    end else begin
      rdata_reg <= 32'h0;
    end
  end
  assign rdata_o = rdata_reg;

  // ==========================================================
  // control outputs
  assign mgmt_irq_o = mgmt_irq_reg;
  assign spare_terminal_drive_o = 1'b0;
  assign spare_terminal_oe_o = cardbus_inserted_i && ctrl_reg[CBSC_B_SPARE_DRV]; // see (RL4)
  assign supply_guard_on_o = !ctrl_reg[CBSC_B_GUARD_OFF]; // see (RL5)
  assign video_addr_float_o = ctrl_reg[CBSC_B_VID_FLOAT]; // see (RL6)
  assign card_dma_req_o = card_dma_request_i && ctrl_reg[CBSC_B_DMA_REQ]; // see (RL7)
  assign card_dma_channel_o = ctrl_reg[CBSC_B_CHAN_HI:CBSC_B_CHAN_LO]; // see (RL8)
  assign read_burst_down_on_o = ctrl_reg[CBSC_B_BURST_DN]; // see (RL9)
  assign read_burst_up_on_o = ctrl_reg[CBSC_B_BURST_UP]; // see (RL10)
  assign auto_switch_on_o = auto_switch_req_i && ctrl_reg[CBSC_B_AUTO_SW]; // see (RL15)
  assign idle_clock_stop_o = ctrl_reg[CBSC_B_IDLE_GATE] && cardbus_inserted_i
                             && card_idle_i && card_clock_stopped_i; // see (RL16)
  assign id_regs_lock_o = ctrl_reg[CBSC_B_ID_LOCK]; // see (RL17)
  assign serr_o = card_parity_err_i && ctrl_reg[CBSC_B_PARITY]; // see (RL18)
  assign central_dma_on_o = ctrl_reg[CBSC_B_CDMA] && central_dma_pins_i; // see (RL19)
  assign legacy_five_volt_o = legacy_mode_i && ctrl_reg[CBSC_B_VOLT]; // see (RL20)
  assign clock_stop_allow_o = clock_stop_req_i && !ctrl_reg[CBSC_B_CLK_BLK]; // see (RL21)
  assign wake_pin_o = ctrl_reg[CBSC_B_WAKE_MUX] ? pme_i
                      : (ring_indicate_out_i || pme_i); // see (RL22)
endmodule

/* File: sim/cbsc_socket_model.sv */
// card socket and power switch model driving the register's event inputs
`timescale 1ns/1ps
module cbsc_socket_model (
  input wire logic clk_i,
  input wire logic [16:0] ev_i,
  output logic [16:0] sock_o = 17'h0
);
  always @(posedge clk_i) sock_o <= ev_i;
endmodule

/* File: sim/cbsc_sysctl_sva.sv */
// port assertions for the system control register
`timescale 1ns/1ps
module cbsc_sysctl_sva
  import cbsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic power_write_i,
  input wire cbsc_power_stat_t power_stat_i,
  input wire logic mgmt_irq_o,
  input wire logic cardbus_inserted_i,
  input wire logic spare_terminal_oe_o,
  input wire logic spare_terminal_drive_o,
  input wire logic card_dma_request_i,
  input wire logic card_dma_req_o,
  input wire logic card_parity_err_i,
  input wire logic serr_o,
  input wire logic pme_i,
  input wire logic wake_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_irq; mgmt_irq_o |-> $past(power_write_i); endproperty
  a_irq: assert property (p_irq) else $error("irq without power write");
  property p_rsvd;
    rd_i && addr_i == CBSC_SYSCTL_OFF |=> rdata_o[12] && !rdata_o[23];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_stat;
    rd_i && addr_i == CBSC_SYSCTL_OFF |=> rdata_o[11:8] == $past(power_stat_i);
  endproperty
  a_stat: assert property (p_stat) else $error("power status wrong");
  property p_spare;
    spare_terminal_oe_o |-> cardbus_inserted_i && !spare_terminal_drive_o;
  endproperty
  a_spare: assert property (p_spare) else $error("spare drive wrong");
  property p_dma; card_dma_req_o |-> card_dma_request_i; endproperty
  a_dma: assert property (p_dma) else $error("dma request invented");
  property p_serr; serr_o |-> card_parity_err_i; endproperty
  a_serr: assert property (p_serr) else $error("serr invented");
  property p_wake; pme_i |-> wake_pin_o; endproperty
  a_wake: assert property (p_wake) else $error("pme lost");
  property p_unmap; rd_i && addr_i != CBSC_SYSCTL_OFF |=> rdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind cbsc_sysctl cbsc_sysctl_sva i_cbsc_sysctl_sva (.*);

/* File: sim/cbsc_sysctl_tb.sv */
// self-checking bench for the system control register
`timescale 1ns/1ps
module cbsc_sysctl_tb;
  import cbsc_pkg::*;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata_o, m, w, st = 32'hae25ea72;
  logic [16:0] ev = 17'h0, s;
  logic [17:0] o;
  logic irq;
  int errors = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  cbsc_socket_model i_cbsc_socket_model (.clk_i(clk_i), .ev_i(ev), .sock_o(s));
  cbsc_sysctl i_cbsc_sysctl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .power_write_i(s[12]), .card_access_i(s[11]),
    .cardbus_inserted_i(s[10]), .card_idle_i(s[9]), .card_clock_stopped_i(s[8]),
    .card_dma_request_i(s[7]), .central_dma_pins_i(s[6]), .card_parity_err_i(s[5]),
    .clock_stop_req_i(s[4]), .ring_indicate_out_i(s[3]), .pme_i(s[2]), .legacy_mode_i(s[1]),
    .auto_switch_req_i(s[0]), .power_stat_i(s[16:13]), .mgmt_irq_o(irq),
    .supply_guard_on_o(o[17]), .video_addr_float_o(o[16]), .card_dma_req_o(o[15]),
    .card_dma_channel_o(o[14:12]), .read_burst_down_on_o(o[11]), .read_burst_up_on_o(o[10]),
    .auto_switch_on_o(o[9]), .idle_clock_stop_o(o[8]), .id_regs_lock_o(o[7]), .serr_o(o[6]),
    .central_dma_on_o(o[5]), .legacy_five_volt_o(o[4]), .clock_stop_allow_o(o[3]),
    .wake_pin_o(o[2]), .spare_terminal_oe_o(o[1]), .spare_terminal_drive_o(o[0]));
  function automatic logic [31:0] nx(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] re();
    return m | 32'h1000 | {16'h0, s[16:13], 12'h0} >> 4;
  endfunction
  function automatic logic [31:0] eo();
    return {14'h0, !m[21], m[20], s[7] & m[19], m[18:16], m[15], m[14], s[0] & m[7],
      m[6] & s[10] & s[9] & s[8], m[5], s[5] & m[4], m[3] & s[6], s[1] & m[2], s[4] & !m[1],
      (m[0] ? s[2] : s[3] | s[2]), s[10] & m[22], 1'b0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk_i);
    wr <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a; rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    #1 chk(rdata_o, e);
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000 errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    m = 32'h00448060;
    rdc(8'h80, re());
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      st = nx(st);
      ev <= {st[16:13], 2'b00, st[10:0]};
      w = nx(st);
      st = w;
      wr_t(i[0] ? 8'h84 : 8'h80, w);
      if (!i[0]) m = (m & ~32'h017fc0ff) | (w & 32'h017fc0ff);
      rdc(8'h80, re());
      chk({14'h0, o}, eo());
      rdc(8'h84, 32'h0);
    end
    $display("field test done");
    for (int k = 0; k < 2; k++) begin
      wr_t(8'h80, k << 24);
      m = k << 24;
      ev <= 17'h1800;
      @(posedge clk_i);
      ev <= 17'h0;
      @(posedge clk_i);
      #1 chk({31'h0, irq}, k);
      repeat (2) @(posedge clk_i);
      m = m | (k << 25) | 32'h2000;
      rdc(8'h80, re());
      m = m & ~32'h2000;
      rdc(8'h80, re());
    end
    wr_t(8'h80, 32'h03000000);
    m = 32'h01000000;
    rdc(8'h80, re());
    $display("event test done");
    conclude();
  end
endmodule
